// ### logic/sensor_irq_and_fifo_pointers.sv
// Functional notes
// - Interrupt pin low while enabled flag set
// - Almost-full flag in particle mode when free slots hit threshold
// - Status-one read clears almost-full, ambient, proximity
// - Data-ready on particle-mode push; cleared by status/data read
// - Ambient-cancel overflow sets its flag
// - Proximity trip sets proximity flag
// - Power-ready flag set after supply/reset recovery
// - Temp-ready on conversion; cleared by status2/fraction
// - Status or source read clears whole register
// - Enables gate sources; power-ready never masked
// - Brownout reset clears all enables
// - Write pointer advances per pushed sample
// - Write-pointer writes only in modes 010/011/111
// - Full FIFO discards new samples
// - Lost counter counts discards, saturates at 0xF
// - Sample pop resets lost counter
// - Read pointer advances per popped sample
// - Host may rewrite read pointer to re-read
// - Circular 32-deep FIFO, pointers wrap
// - Data-port reads keep register address
// - Proximity entry/exit empties FIFO while proximity enable set
module sensor_irq_and_fifo_pointers
  import sensor_irq_pkg::*;
#(
  parameter logic [7:0] PART_CODE     = 8'h5a, // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01  // Arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic        i_req_setaddr,
  input  wire logic        i_req_write,
  input  wire logic [7:0]  i_req_data,
  output logic             o_rsp_valid,
  input  wire logic        i_rsp_ready,
  output logic [7:0]       o_rsp_data,
  input  wire logic        i_sample_push,
  input  wire logic [23:0] i_sample_data,
  input  wire logic        i_particle_mode,
  input  wire logic [2:0]  i_mode,
  input  wire logic [3:0]  i_almost_full_free,
  input  wire logic        i_ambient_cancel_overflow,
  input  wire logic        i_prox_trip,
  input  wire logic        i_prox_mode_change,
  input  wire logic        i_temp_done,
  input  wire logic [7:0]  i_temp_whole,
  input  wire logic [3:0]  i_temp_frac,
  input  wire logic        i_temp_busy,
  output logic             o_int_b,
  output logic             o_proximity_trip_enable,
  output logic [7:0]       o_prox_trip_level
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pointer difference wraps modulo the depth
  function automatic logic [4:0] fifo_used(input logic [4:0] wr, input logic [4:0] rd);
    fifo_used = wr - rd;
  endfunction

  // Address pointer steps except on the data port and the last register
  function automatic logic [7:0] next_addr(input logic [7:0] a);
    if (a == ADDR_READ_PORT || a == ADDR_PART) begin
      next_addr = a;
    end else begin
      next_addr = a + 8'h01;
    end
  endfunction

  state_type           cur;
  state_type           nxt;
  logic [SAMPLE_W-1:0] mem [FIFO_DEPTH];
  logic [SAMPLE_W-1:0] head;
  logic [7:0]          rdata;
  logic [4:0]          free_slots;
  logic                full;
  logic                empty;
  logic                fire;
  logic                rd_fire;
  logic                wr_fire;
  logic                pop;
  logic                push_ok;
  logic                clr_main;
  logic                clr_temp;
  logic                deq;
  logic                ptr_mode_ok;

  // ----------------------------------------------------------------
  // Occupancy and handshakes
  // ----------------------------------------------------------------
  // One slot stays unused so equal pointers always mean empty
  assign free_slots  = FREE_MAX - fifo_used(cur.push_idx, cur.pop_idx);
  assign full        = (free_slots == 5'h00);
  assign empty       = (cur.push_idx == cur.pop_idx);
  assign push_ok     = i_sample_push && !full;
  assign o_req_ready = (cur.buf_cnt != BUF_FULL);
  assign fire        = i_req_valid && o_req_ready;
  assign rd_fire     = fire && !i_req_setaddr && !i_req_write;
  assign wr_fire     = fire && !i_req_setaddr && i_req_write;
  assign deq         = o_rsp_valid && i_rsp_ready;
  assign head        = mem[cur.pop_idx];
  assign ptr_mode_ok = (i_mode == MODE_PTR_A) || (i_mode == MODE_PTR_B) ||
                       (i_mode == MODE_PTR_C);

  // Sample store, no reset needed
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem[cur.push_idx] <= i_sample_data;
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Unmapped addresses read as zero
  always_comb begin
    rdata    = 8'h00;
    pop      = 1'b0;
    clr_main = 1'b0;
    clr_temp = 1'b0;
    if (rd_fire) begin
      if (cur.addr == ADDR_FLAGS_MAIN) begin
        rdata    = cur.flags_main;
        clr_main = 1'b1;
      end else if (cur.addr == ADDR_FLAGS_TEMP) begin
        rdata    = cur.flags_temp;
        clr_temp = 1'b1;
      end else if (cur.addr == ADDR_MASK_MAIN) begin
        rdata = cur.mask_main;
      end else if (cur.addr == ADDR_MASK_TEMP) begin
        rdata = cur.mask_temp;
      end else if (cur.addr == ADDR_PUSH_INDEX) begin
        rdata = {3'h0, cur.push_idx};
      end else if (cur.addr == ADDR_LOST_COUNT) begin
        rdata = {3'h0, cur.lost};
      end else if (cur.addr == ADDR_POP_INDEX) begin
        rdata = {3'h0, cur.pop_idx};
      end else if (cur.addr == ADDR_READ_PORT) begin
        clr_main = 1'b1;
        if (cur.byte_idx == 2'h0) begin
          rdata = head[23:16];
          pop   = !empty; // Empty FIFO is read but not popped
        end else if (cur.byte_idx == 2'h1) begin
          rdata = cur.sample[15:8];
        end else begin
          rdata = cur.sample[7:0];
        end
      end else if (cur.addr == ADDR_TEMP_WHOLE) begin
        rdata = cur.temp_whole;
      end else if (cur.addr == ADDR_TEMP_FRAC) begin
        rdata    = {4'h0, cur.temp_frac};
        clr_temp = 1'b1;
      end else if (cur.addr == ADDR_TEMP_START) begin
        rdata = {7'h00, i_temp_busy};
      end else if (cur.addr == ADDR_PROX_LEVEL) begin
        rdata = cur.prox_level;
      end else if (cur.addr == ADDR_REVISION) begin
        rdata = REVISION_CODE;
      end else if (cur.addr == ADDR_PART) begin
        rdata = PART_CODE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = cur;
    // Address pointer and byte position within a sample
    if (fire && i_req_setaddr) begin
      nxt.addr     = i_req_data;
      nxt.byte_idx = 2'h0;
    end else if (fire) begin
      nxt.addr = next_addr(cur.addr);
    end
    if (rd_fire && cur.addr == ADDR_READ_PORT) begin
      nxt.byte_idx = (cur.byte_idx == LAST_BYTE) ? 2'h0 : cur.byte_idx + 2'h1;
      if (cur.byte_idx == 2'h0) begin
        nxt.sample = head;
      end
    end

    // Host writes; unused enable bits are dropped
    if (wr_fire) begin
      if (cur.addr == ADDR_MASK_MAIN) begin
        nxt.mask_main = i_req_data & MAIN_ENABLE_USED;
      end else if (cur.addr == ADDR_MASK_TEMP) begin
        nxt.mask_temp = i_req_data & TEMP_ENABLE_USED;
      end else if (cur.addr == ADDR_PUSH_INDEX && ptr_mode_ok) begin
        nxt.push_idx = i_req_data[4:0];
      end else if (cur.addr == ADDR_LOST_COUNT) begin
        nxt.lost = i_req_data[4:0];
      end else if (cur.addr == ADDR_POP_INDEX) begin
        nxt.pop_idx = i_req_data[4:0];
      end else if (cur.addr == ADDR_PROX_LEVEL) begin
        nxt.prox_level = i_req_data;
      end
    end

    // Hardware pointer motion outranks a host write in the same cycle
    if (push_ok) begin
      nxt.push_idx = cur.push_idx + 5'h01;
    end else if (i_sample_push && cur.lost < LOST_MAX) begin
      nxt.lost = cur.lost + 5'h01;
    end
    if (pop) begin
      nxt.pop_idx = cur.pop_idx + 5'h01;
      nxt.lost    = 5'h00;
    end
    if (i_prox_mode_change && cur.mask_main[BIT_PROX]) begin
      nxt.pop_idx = nxt.push_idx;
    end

    // Flags: clear first so a same-cycle event still sets
    if (clr_main) begin
      nxt.flags_main = 8'h00;
    end
    if (clr_temp) begin
      nxt.flags_temp = 8'h00;
    end
    if (push_ok && i_particle_mode) begin
      nxt.flags_main[BIT_DATA_READY] = 1'b1;
      if ({1'b0, i_almost_full_free} == free_slots - 5'h01) begin
        nxt.flags_main[BIT_ALMOST_FULL] = 1'b1;
      end
    end
    if (i_ambient_cancel_overflow) begin
      nxt.flags_main[BIT_AMBIENT] = 1'b1;
    end
    if (i_prox_trip) begin
      nxt.flags_main[BIT_PROX] = 1'b1;
    end
    // Reset stands for supply recovery, so first live cycle raises it
    if (!cur.power_seen) begin
      nxt.power_seen             = 1'b1;
      nxt.flags_main[BIT_POWER] = 1'b1;
    end
    if (i_temp_done) begin
      nxt.flags_temp[BIT_TEMP_READY] = 1'b1;
      nxt.temp_whole                 = i_temp_whole;
      nxt.temp_frac                  = i_temp_frac;
    end

    // Two-entry answer buffer; full buffer stalls new requests
    if (deq) begin
      nxt.buf0    = cur.buf1;
      nxt.buf_cnt = cur.buf_cnt - 2'h1;
    end
    if (rd_fire) begin
      if (nxt.buf_cnt == 2'h0) begin
        nxt.buf0 = rdata;
      end else begin
        nxt.buf1 = rdata;
      end
      nxt.buf_cnt = nxt.buf_cnt + 2'h1;
    end
  end

  // Every state field, enables included, returns to zero on brownout
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cur <= STATE_RESET;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Power flag bypasses the enables
  assign o_int_b = !(|(cur.flags_main & cur.mask_main) ||
                     cur.flags_main[BIT_POWER] ||
                     |(cur.flags_temp & cur.mask_temp));
  assign o_rsp_valid             = (cur.buf_cnt != 2'h0);
  assign o_rsp_data              = cur.buf0;
  assign o_proximity_trip_enable = cur.mask_main[BIT_PROX];
  assign o_prox_trip_level       = cur.prox_level;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_data_read;
    rd_fire && cur.addr == ADDR_READ_PORT;
  endsequence

  sequence s_quiet_main;
    !i_sample_push && !i_ambient_cancel_overflow && !i_prox_trip && cur.power_seen;
  endsequence

  a_int_enabled_low: assert property (
    (cur.flags_main[BIT_DATA_READY] && cur.mask_main[BIT_DATA_READY]) |-> !o_int_b)
    else $error("interrupt pin high with enabled flag set");

  a_power_unmasked: assert property (
    $rose(cur.flags_main[BIT_POWER]) |-> !o_int_b)
    else $error("power flag did not reach the pin");

  a_ready_on_push: assert property (
    (push_ok && i_particle_mode) |=> cur.flags_main[BIT_DATA_READY])
    else $error("data ready not set after push");

  a_status_read_clears: assert property (
    (rd_fire && cur.addr == ADDR_FLAGS_MAIN) ##0 s_quiet_main |=>
      (cur.flags_main == 8'h00) && o_int_b == !(|(cur.flags_temp & cur.mask_temp)))
    else $error("status read left flags set");

  a_data_read_clears: assert property (
    s_data_read ##0 s_quiet_main |=> cur.flags_main == 8'h00)
    else $error("data port read left flags set");

  a_temp_flag_clears: assert property (
    (rd_fire && cur.addr == ADDR_TEMP_FRAC && !i_temp_done) |=> cur.flags_temp == 8'h00)
    else $error("fraction read left temperature flag");

  a_push_advances: assert property (
    (push_ok && !i_prox_mode_change) |=> cur.push_idx == $past(cur.push_idx) + 5'h01)
    else $error("write index did not step on push");

  a_index_write_gated: assert property (
    (wr_fire && cur.addr == ADDR_PUSH_INDEX && !ptr_mode_ok && !i_sample_push) |=>
      $stable(cur.push_idx))
    else $error("write index changed outside allowed modes");

  a_lost_counts: assert property (
    (i_sample_push && full && cur.lost < LOST_MAX && !pop && !wr_fire) |=>
      cur.lost == $past(cur.lost) + 5'h01 && $stable(cur.push_idx))
    else $error("discarded sample not counted");

  a_lost_saturates: assert property (
    (cur.lost == LOST_MAX && !wr_fire && !pop) |=> cur.lost == LOST_MAX)
    else $error("lost counter passed its ceiling");

  a_pop_resets_lost: assert property (
    pop |=> cur.lost == 5'h00 && cur.pop_idx != $past(cur.pop_idx))
    else $error("pop did not reset lost counter");

  a_addr_holds_port: assert property (
    s_data_read ##1 (rd_fire && !i_req_setaddr) |-> cur.addr == ADDR_READ_PORT)
    else $error("data port address moved");

  a_answer_holds: assert property (
    (o_rsp_valid && !i_rsp_ready) |=> o_rsp_valid && $stable(o_rsp_data))
    else $error("stalled answer changed");

  a_full_discards: assert property (
    (i_sample_push && full && !wr_fire) |=> $stable(cur.push_idx))
    else $error("sample stored into a full FIFO");

  a_pop_steps: assert property (
    (pop && !i_prox_mode_change) |=> cur.pop_idx == $past(cur.pop_idx) + 5'h01)
    else $error("read index did not step on pop");

  a_prox_empties: assert property (
    (i_prox_mode_change && cur.mask_main[BIT_PROX]) |=> empty)
    else $error("proximity change left FIFO occupied");

  a_power_raised: assert property (
    !cur.power_seen |=> cur.flags_main[BIT_POWER] && cur.power_seen)
    else $error("power flag not raised after reset");

  a_temp_ready_sets: assert property (
    i_temp_done |=> cur.flags_temp[BIT_TEMP_READY] && cur.temp_frac == $past(i_temp_frac))
    else $error("temperature flag not set on conversion");

  // Checked one cycle on, once the push has moved the free count
  a_almost_full_sets: assert property (
    (push_ok && i_particle_mode && !pop && !wr_fire && !i_prox_mode_change) |=>
      (free_slots != {1'b0, $past(i_almost_full_free)}) ||
      cur.flags_main[BIT_ALMOST_FULL])
    else $error("almost-full flag missed its threshold");

endmodule

// ### logic/sensor_irq_pkg.sv
package sensor_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS_MAIN = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_TEMP = 8'h01;
  localparam logic [7:0] ADDR_MASK_MAIN  = 8'h02;
  localparam logic [7:0] ADDR_MASK_TEMP  = 8'h03;
  localparam logic [7:0] ADDR_PUSH_INDEX = 8'h04;
  localparam logic [7:0] ADDR_LOST_COUNT = 8'h05;
  localparam logic [7:0] ADDR_POP_INDEX  = 8'h06;
  localparam logic [7:0] ADDR_READ_PORT  = 8'h07;
  localparam logic [7:0] ADDR_TEMP_WHOLE = 8'h1f;
  localparam logic [7:0] ADDR_TEMP_FRAC  = 8'h20;
  localparam logic [7:0] ADDR_TEMP_START = 8'h21;
  localparam logic [7:0] ADDR_PROX_LEVEL = 8'h30;
  localparam logic [7:0] ADDR_REVISION   = 8'hfe;
  localparam logic [7:0] ADDR_PART       = 8'hff;

  // ----------------------------------------------------------------
  // Flag and enable bit positions
  // ----------------------------------------------------------------
  localparam int BIT_ALMOST_FULL = 7;
  localparam int BIT_DATA_READY  = 6;
  localparam int BIT_AMBIENT     = 5;
  localparam int BIT_PROX        = 4;
  localparam int BIT_POWER       = 0;
  localparam int BIT_TEMP_READY  = 1;
  localparam logic [7:0] MAIN_ENABLE_USED = 8'hf0;
  localparam logic [7:0] TEMP_ENABLE_USED = 8'h02;

  // ----------------------------------------------------------------
  // FIFO geometry and counts
  // ----------------------------------------------------------------
  localparam int          PTR_W         = 5;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          SAMPLE_W      = 24;
  localparam logic [4:0]  FREE_MAX      = 5'h1f;
  localparam logic [4:0]  LOST_MAX      = 5'h0f;
  localparam logic [1:0]  LAST_BYTE     = 2'h2;
  localparam logic [1:0]  BUF_FULL      = 2'h2;
  localparam logic [2:0]  MODE_PTR_A    = 3'h2;
  localparam logic [2:0]  MODE_PTR_B    = 3'h3;
  localparam logic [2:0]  MODE_PTR_C    = 3'h7;

  // ----------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [4:0]  push_idx;
    logic [4:0]  pop_idx;
    logic [4:0]  lost;
    logic [7:0]  flags_main;
    logic [7:0]  flags_temp;
    logic [7:0]  mask_main;
    logic [7:0]  mask_temp;
    logic [7:0]  prox_level;
    logic [7:0]  temp_whole;
    logic [3:0]  temp_frac;
    logic [1:0]  byte_idx;
    logic [23:0] sample;
    logic        power_seen;
    logic [7:0]  buf0;
    logic [7:0]  buf1;
    logic [1:0]  buf_cnt;
  } state_type;

  localparam state_type STATE_RESET = '0;

endpackage

// ### tb/host_model.sv
module host_model (
  input  wire logic       i_clk,
  input  wire logic       i_req_ready,
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_data,
  output logic            o_req_valid,
  output logic            o_req_setaddr,
  output logic            o_req_write,
  output logic [7:0]      o_req_data,
  output logic            o_rsp_ready,
  output logic            o_stuck
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Host side of the register port
  // ------------------------------------------------------------
  // Idle state at time zero
  initial begin
    o_req_valid   = 1'b0;
    o_req_setaddr = 1'b0;
    o_req_write   = 1'b0;
    o_req_data    = 8'h00;
    o_rsp_ready   = 1'b0;
    o_stuck       = 1'b0;
  end

  // Request held until an edge that sees ready high
  task automatic issue(input logic sa, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    o_req_setaddr = sa;
    o_req_write   = wr;
    o_req_data    = d;
    o_req_valid   = 1'b1;
    while (i_req_ready !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 50) o_stuck = 1'b1;
    @(negedge i_clk);
    o_req_valid = 1'b0;
    o_req_data  = ~d; // Released bus never shows the last value
  endtask

  // Answer byte captured before the edge that takes it
  task automatic take(output logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    o_rsp_ready = 1'b1;
    while (i_rsp_valid !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    if (n == 50) o_stuck = 1'b1;
    d = i_rsp_data;
    @(negedge i_clk);
    o_rsp_ready = 1'b0;
  endtask
endmodule

// ### tb/sensor_irq_and_fifo_pointers_bench.sv
module sensor_irq_and_fifo_pointers_bench
  import sensor_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Stimulus and wiring
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic        pmode = 1'b0;
  logic        tbusy = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [3:0]  afree = 4'h0;
  logic [23:0] sdata = 24'h000000;
  logic [7:0]  twhole = 8'h00;
  logic [3:0]  die_temp_frac = 4'h0;
  logic [7:0]  sn = 8'h00;
  logic        rv, rsa, rwr, rspr, stuck, rqr, rspv, int_b, pte;
  logic [7:0]  rdat, rspd, ptl, d, last;
  int          err_total = 0;
  int          checked = 0;

  always #4 clk = ~clk;

  sensor_irq_and_fifo_pointers #(.PART_CODE(8'h3c), .REVISION_CODE(8'h07)) dut_u (
    .i_clk(clk), .i_rst_b(rst_b), .i_req_valid(rv), .o_req_ready(rqr),
    .i_req_setaddr(rsa), .i_req_write(rwr), .i_req_data(rdat),
    .o_rsp_valid(rspv), .i_rsp_ready(rspr), .o_rsp_data(rspd),
    .i_sample_push(ev[4]), .i_sample_data(sdata), .i_particle_mode(pmode),
    .i_mode(mode), .i_almost_full_free(afree), .i_ambient_cancel_overflow(ev[0]),
    .i_prox_trip(ev[1]), .i_prox_mode_change(ev[2]), .i_temp_done(ev[3]),
    .i_temp_whole(twhole), .i_temp_frac(die_temp_frac), .i_temp_busy(tbusy),
    .o_int_b(int_b), .o_proximity_trip_enable(pte), .o_prox_trip_level(ptl));

  host_model host_u (
    .i_clk(clk), .i_req_ready(rqr), .i_rsp_valid(rspv), .i_rsp_data(rspd),
    .o_req_valid(rv), .o_req_setaddr(rsa), .o_req_write(rwr),
    .o_req_data(rdat), .o_rsp_ready(rspr), .o_stuck(stuck));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A host wait that ran out is a failure
  always @(posedge stuck) begin
    err_total++;
    report_and_stop();
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.issue(1'b1, 1'b0, a);
    host_u.issue(1'b0, 1'b1, v);
  endtask

  task automatic rdn(output logic [7:0] v);
    host_u.issue(1'b0, 1'b0, 8'h00);
    host_u.take(v);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    host_u.issue(1'b1, 1'b0, a);
    rdn(v);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // One-cycle event pulse on the chosen input
  task automatic pulse(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask

  // Sample sn, counted from the last reset, carries sn in its first byte
  task automatic push(input int n);
    for (int k = 0; k < n; k++) begin
      sdata = {sn, 8'h5c, ~sn};
      sn = sn + 8'h01;
      pulse(4);
    end
  endtask

  task automatic reset;
    rst_b = 1'b0;
    sn = 8'h00;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset();
    chk({7'h0, int_b}, 8'h00);
    rc(ADDR_FLAGS_MAIN, 8'h01);
    chk({7'h0, int_b}, 8'h01);
    for (int a = 1; a < 7; a++) rc(8'(a), 8'h00);
    rc(ADDR_PART, 8'h3c);
    wr(ADDR_PART, 8'h00);
    rc(ADDR_PART, 8'h3c);
    rc(8'h50, 8'h00);
    rc(ADDR_REVISION, 8'h07);
    tbusy = 1'b1;
    rc(ADDR_TEMP_START, 8'h01);
    tbusy = 1'b0;
    wr(ADDR_PROX_LEVEL, 8'h96);
    chk(ptl, 8'h96);
    // Flags through the enables
    wr(ADDR_MASK_MAIN, 8'hf0);
    rc(ADDR_MASK_MAIN, 8'hf0);
    pulse(0);
    chk({7'h0, int_b}, 8'h00);
    rc(ADDR_FLAGS_MAIN, 8'h20);
    chk({7'h0, int_b}, 8'h01);
    pulse(1);
    rc(ADDR_FLAGS_MAIN, 8'h10);
    chk({7'h0, pte}, 8'h01);
    wr(ADDR_MASK_MAIN, 8'h00);
    pulse(0);
    chk({7'h0, int_b}, 8'h01);
    rc(ADDR_FLAGS_MAIN, 8'h20);
    // Temperature flag cleared by the fraction read
    twhole = 8'h19;
    die_temp_frac = 4'h4;
    wr(ADDR_MASK_TEMP, 8'h02);
    pulse(3);
    chk({7'h0, int_b}, 8'h00);
    rc(ADDR_TEMP_WHOLE, 8'h19);
    rc(ADDR_TEMP_FRAC, 8'h04);
    chk({7'h0, int_b}, 8'h01);
    rc(ADDR_FLAGS_TEMP, 8'h00);
    // Two answers pending with the host stalled
    host_u.issue(1'b1, 1'b0, ADDR_PART);
    host_u.issue(1'b0, 1'b0, 8'h00);
    host_u.issue(1'b0, 1'b0, 8'h00);
    @(negedge clk);
    chk({7'h0, rqr}, 8'h00);
    host_u.take(d);
    chk(d, 8'h3c);
    host_u.take(d);
    chk(d, 8'h3c);
    // Pointers and the data port
    pmode = 1'b1;
    wr(ADDR_MASK_MAIN, 8'h40);
    push(3);
    chk({7'h0, int_b}, 8'h00);
    rc(ADDR_PUSH_INDEX, 8'h03);
    rc(ADDR_FLAGS_MAIN, 8'h40);
    rd(ADDR_READ_PORT, d);
    chk(d, 8'h00);
    rdn(d);
    chk(d, 8'h5c);
    rdn(d);
    chk(d, 8'hff);
    rdn(d);
    chk(d, 8'h01);
    rc(ADDR_POP_INDEX, 8'h02);
    wr(ADDR_POP_INDEX, 8'h00);
    rd(ADDR_READ_PORT, d);
    chk(d, 8'h00);
    push(1);
    rd(ADDR_READ_PORT, d);
    rc(ADDR_FLAGS_MAIN, 8'h00);
    // Host write to the push index in every mode
    last = 8'h04;
    for (int m = 0; m < 8; m++) begin
      mode = 3'(m);
      wr(ADDR_PUSH_INDEX, 8'(8 + m));
      if (m == 2 || m == 3 || m == 7) last = 8'(8 + m);
      rc(ADDR_PUSH_INDEX, last);
    end
    wr(ADDR_MASK_MAIN, 8'h10);
    pulse(2);
    rc(ADDR_POP_INDEX, last);
    // Second reset, then fill to full and overflow
    reset();
    chk({7'h0, int_b}, 8'h00);
    rc(ADDR_MASK_MAIN, 8'h00);
    afree = 4'h2;
    push(28);
    rc(ADDR_FLAGS_MAIN, 8'h41);
    push(1);
    rc(ADDR_FLAGS_MAIN, 8'hc0);
    push(19);
    rc(ADDR_PUSH_INDEX, 8'h1f);
    rc(ADDR_LOST_COUNT, 8'h0f);
    rd(ADDR_READ_PORT, d);
    chk(d, 8'h00);
    rc(ADDR_LOST_COUNT, 8'h00);
    push(1);
    rc(ADDR_PUSH_INDEX, 8'h00);
    report_and_stop();
  end
endmodule
